// ==== hdl/ain_fault_pkg.sv ====
package ain_fault_pkg;

    localparam int NUM_CH   = 4;
    localparam int DATA_W   = 16;

    // APB register byte offsets.
    localparam logic [7:0] OFS_GLOBAL   = 8'h00;
    localparam logic [7:0] OFS_CHCFG0   = 8'h04;
    localparam logic [7:0] OFS_MINVAL0  = 8'h14;
    localparam logic [7:0] OFS_FLAGS0   = 8'h24;
    localparam logic [7:0] OFS_CJCTEMP0 = 8'h34;
    localparam logic [7:0] OFS_DATA0    = 8'h44;
    localparam logic [7:0] OFS_MODFLAGS = 8'h54;

    // Global control bits.
    localparam int GBL_ALARM_DIS = 0;
    localparam int GBL_CJC_DIS   = 1;

    // Channel configuration fields.
    localparam int CFG_MODE_LSB  = 0;
    localparam int CFG_UNIT_LSB  = 2;
    localparam int CFG_WIRE_EN   = 5;
    localparam int CFG_ALARM_EN  = 6;

    // Per-channel flag word bit positions.
    localparam int FLG_WIRE_BREAK  = 0;
    localparam int FLG_BAD_QUAL    = 1;
    localparam int FLG_BELOW_MIN   = 2;
    localparam int FLG_OVERHEAT    = 3;
    localparam int FLG_CJ_WIRE     = 4;
    localparam int FLG_CJ_BAD_QUAL = 5;
    localparam int FLG_CJ_BELOW    = 6;
    localparam int FLG_ALARM       = 7;
    localparam int FLG_W           = 8;

    // Reset values.
    localparam logic [31:0] RST_GLOBAL = 32'h0000_0000;
    localparam logic [31:0] RST_CHCFG  = 32'h0000_0020;
    localparam logic [31:0] RST_MINVAL = 32'h0000_8000;

    // Current below this many microamps counts as an open loop.
    localparam int WIRE_CURRENT_UA = 100;

    typedef enum logic [1:0] {
        MODE_CURRENT = 2'h0,
        MODE_VOLTAGE = 2'h1,
        MODE_RTD     = 2'h2,
        MODE_TC      = 2'h3
    } in_mode_t;

    typedef enum logic [2:0] {
        UNIT_CELSIUS    = 3'h0,
        UNIT_KELVIN     = 3'h1,
        UNIT_FAHRENHEIT = 3'h2,
        UNIT_RANKINE    = 3'h3,
        UNIT_CUSTOM     = 3'h4
    } temp_unit_t;

endpackage

// ==== hdl/analog_input_fault_status.sv ====
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Open-wire detection keeps working while all alarms are disabled.
// - Global alarm-disable suppresses every alarm on every channel.
// - A broken wire raises its open-wire and channel fault flags, never an alarm.
// - Only the per-channel enable turns open-wire detection off.
// - Each channel holds its own unit: C, K, F, R or custom.
// - Over-temperature sets each channel overheat flag to 1.
// - Thermocouple readings are corrected with the cold-junction value.
// - A configuration bit disables cold-junction correction.
// - Flags are reported together with channel data in every report.
// - Flags are kept per channel; few module-wide flags have no index.
// - Connection-fault flag asserts while the owner link is lost.
// - Channel fault flag asserts when channel data quality is bad.
// - Cold-junction fault flag asserts when its data quality is bad.
// - Voltage mode: full-scale input raises the open-wire flag.
// - Current mode: input under 100 microamps raises the open-wire flag.
// - RTD or thermocouple: disconnected wire raises the open-wire flag.
// - Disconnected cold-junction sensor raises its open-wire flag.
// - Channel data below its minimum raises the underrange flag.
// - Cold-junction reading below channel minimum raises its underrange.
// - Open-wire also sets the channel fault flag.
module analog_input_fault_status #(
    parameter int NUM_CH = ain_fault_pkg::NUM_CH,
    parameter int DATA_W = ain_fault_pkg::DATA_W
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       sample_strobe,
    input  wire logic [NUM_CH*DATA_W-1:0]   raw_data,
    input  wire logic [NUM_CH*DATA_W-1:0]   cj_data,
    input  wire logic [NUM_CH-1:0]          raw_full_scale,
    input  wire logic [NUM_CH-1:0]          raw_low_current,
    input  wire logic [NUM_CH-1:0]          raw_wire_open,
    input  wire logic [NUM_CH-1:0]          raw_bad_quality,
    input  wire logic [NUM_CH-1:0]          cj_wire_open,
    input  wire logic [NUM_CH-1:0]          cj_bad_quality,
    input  wire logic [NUM_CH-1:0]          alarm_cond,
    input  wire logic                       over_temp,
    input  wire logic                       owner_link_ok,
    output logic                            report_valid,
    output logic [NUM_CH*DATA_W-1:0]        report_data,
    output logic [NUM_CH*ain_fault_pkg::FLG_W-1:0] report_flags,
    output logic [NUM_CH*3-1:0]             report_units,
    output logic                            owner_link_lost_flag
);

    localparam int FW = ain_fault_pkg::FLG_W;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for asynchronous field-side status levels.

    localparam int SW = 6 * NUM_CH + 2;

    // The link-good level sits in bit 0 and resets to its idle level, so a
    // reset never shows a false loss of the owner link.
    localparam logic [SW-1:0] SYNC_RST = {{(SW-1){1'b0}}, 1'b1};

    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    logic [SW-1:0] async_in;

    assign async_in = {raw_full_scale, raw_low_current, raw_wire_open,
                       raw_bad_quality, cj_wire_open, cj_bad_quality,
                       over_temp, owner_link_ok};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end else begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
        end
    end

    logic [NUM_CH-1:0] s_full;
    logic [NUM_CH-1:0] s_lowcur;
    logic [NUM_CH-1:0] s_wire;
    logic [NUM_CH-1:0] s_badq;
    logic [NUM_CH-1:0] s_cjwire;
    logic [NUM_CH-1:0] s_cjbadq;
    logic              s_overtemp;
    logic              s_link_ok;

    assign {s_full, s_lowcur, s_wire, s_badq, s_cjwire, s_cjbadq,
            s_overtemp, s_link_ok} = sync2_ff;

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [31:0] global_ff;
    logic [31:0] chcfg_ff  [NUM_CH];
    logic [31:0] minval_ff [NUM_CH];

    // True when the address selects channel ch of a per-channel block.
    function automatic logic hit_ch(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input int         ch);
        return a == 8'(base + 8'(ch * 4));
    endfunction

    // Only the five defined unit codes can be held; an undefined code that
    // software writes falls back to the custom unit.
    function automatic logic [2:0] legal_unit(input logic [2:0] u);
        unique case (u)
            ain_fault_pkg::UNIT_CELSIUS,
            ain_fault_pkg::UNIT_KELVIN,
            ain_fault_pkg::UNIT_FAHRENHEIT,
            ain_fault_pkg::UNIT_RANKINE,
            ain_fault_pkg::UNIT_CUSTOM: return u;
            default:                    return ain_fault_pkg::UNIT_CUSTOM;
        endcase
    endfunction

    logic wr_en;
    assign wr_en = psel & penable & pwrite;

    // Only the two defined control bits are stored; the rest read as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_ff <= ain_fault_pkg::RST_GLOBAL;
        end else if (wr_en && paddr == ain_fault_pkg::OFS_GLOBAL) begin
            global_ff <= {30'h0, pwdata[1:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                chcfg_ff[i] <= ain_fault_pkg::RST_CHCFG;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_en && hit_ch(paddr, ain_fault_pkg::OFS_CHCFG0, i)) begin
                    chcfg_ff[i] <= {25'h0, pwdata[6:5],
                                    legal_unit(pwdata[4:2]),
                                    pwdata[1:0]};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                minval_ff[i] <= ain_fault_pkg::RST_MINVAL;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_en && hit_ch(paddr, ain_fault_pkg::OFS_MINVAL0, i)) begin
                    minval_ff[i] <= {{(32-DATA_W){1'b0}}, pwdata[DATA_W-1:0]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag evaluation, refreshed on each sample strobe.

    logic [NUM_CH*FW-1:0]     nxt_flags;
    logic [NUM_CH*DATA_W-1:0] nxt_data;
    logic [NUM_CH*FW-1:0]     flags_ff;
    logic [NUM_CH*DATA_W-1:0] data_ff;
    logic [NUM_CH*3-1:0]      units_ff;
    logic                     valid_ff;
    logic                     link_lost_ff;

    always_comb begin
        logic [1:0]        mode;
        logic              wire_brk;
        logic signed [DATA_W-1:0] d;
        logic signed [DATA_W-1:0] cj;
        logic signed [DATA_W-1:0] mn;
        mode     = '0;
        wire_brk = 1'b0;
        d        = '0;
        cj       = '0;
        mn       = '0;
        nxt_flags = '0;
        nxt_data  = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            mode = chcfg_ff[i][ain_fault_pkg::CFG_MODE_LSB +: 2];
            d    = raw_data[i*DATA_W +: DATA_W];
            cj   = cj_data[i*DATA_W +: DATA_W];
            mn   = minval_ff[i][DATA_W-1:0];
            // The open-wire cause depends on the input mode of the channel.
            unique case (mode)
                ain_fault_pkg::MODE_VOLTAGE: wire_brk = s_full[i];
                ain_fault_pkg::MODE_CURRENT: wire_brk = s_lowcur[i];
                ain_fault_pkg::MODE_RTD:     wire_brk = s_wire[i];
                ain_fault_pkg::MODE_TC:      wire_brk = s_wire[i];
            endcase
            // Alarm disable is deliberately not in this term.
            wire_brk = wire_brk & chcfg_ff[i][ain_fault_pkg::CFG_WIRE_EN];
            nxt_flags[i*FW + ain_fault_pkg::FLG_WIRE_BREAK] = wire_brk;
            nxt_flags[i*FW + ain_fault_pkg::FLG_BAD_QUAL] =
                s_badq[i] | wire_brk;
            // Both compares are signed; the reset minimum is the most
            // negative code and so never raises an underrange flag.
            nxt_flags[i*FW + ain_fault_pkg::FLG_BELOW_MIN] = d < mn;
            nxt_flags[i*FW + ain_fault_pkg::FLG_OVERHEAT] = s_overtemp;
            nxt_flags[i*FW + ain_fault_pkg::FLG_CJ_WIRE] = s_cjwire[i];
            nxt_flags[i*FW + ain_fault_pkg::FLG_CJ_BAD_QUAL] = s_cjbadq[i];
            nxt_flags[i*FW + ain_fault_pkg::FLG_CJ_BELOW] = cj < mn;
            // A broken wire never feeds the alarm path.
            nxt_flags[i*FW + ain_fault_pkg::FLG_ALARM] = alarm_cond[i]
                & chcfg_ff[i][ain_fault_pkg::CFG_ALARM_EN]
                & ~global_ff[ain_fault_pkg::GBL_ALARM_DIS];
            if (mode == ain_fault_pkg::MODE_TC
                && !global_ff[ain_fault_pkg::GBL_CJC_DIS]) begin
                nxt_data[i*DATA_W +: DATA_W] = DATA_W'(d + cj);
            end else begin
                nxt_data[i*DATA_W +: DATA_W] = d;
            end
        end
    end

    // Each report carries flags with data; flags are levels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= '0;
        end else if (sample_strobe) begin
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ff <= '0;
        end else if (sample_strobe) begin
            data_ff <= nxt_data;
        end
    end

    // Units travel with each report so a listener never pairs new data
    // with a unit code that software changed in between.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            units_ff <= '0;
        end else if (sample_strobe) begin
            for (int i = 0; i < NUM_CH; i++) begin
                units_ff[i*3 +: 3] <=
                    chcfg_ff[i][ain_fault_pkg::CFG_UNIT_LSB +: 3];
            end
        end
    end

    // The report pulse comes one cycle after the strobe that took it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= sample_strobe;
        end
    end

    // Module-wide flag, follows the link at every cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_lost_ff <= 1'b0;
        end else begin
            link_lost_ff <= ~s_link_ok;
        end
    end

    assign report_valid         = valid_ff;
    assign report_data          = data_ff;
    assign report_flags         = flags_ff;
    assign report_units         = units_ff;
    assign owner_link_lost_flag = link_lost_ff;

    ////////////////////////////////////////////////////////////////////////
    // APB read path; zero wait states.

    logic [31:0] nxt_rdata;
    logic        nxt_err;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = 1'b1;
        if (paddr == ain_fault_pkg::OFS_GLOBAL) begin
            nxt_rdata = global_ff;
            nxt_err   = 1'b0;
        end
        if (paddr == ain_fault_pkg::OFS_MODFLAGS) begin
            nxt_rdata = {31'h0, link_lost_ff};
            nxt_err   = 1'b0;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (hit_ch(paddr, ain_fault_pkg::OFS_CHCFG0, i)) begin
                nxt_rdata = chcfg_ff[i];
                nxt_err   = 1'b0;
            end
            if (hit_ch(paddr, ain_fault_pkg::OFS_MINVAL0, i)) begin
                nxt_rdata = minval_ff[i];
                nxt_err   = 1'b0;
            end
            if (hit_ch(paddr, ain_fault_pkg::OFS_FLAGS0, i)) begin
                nxt_rdata = {{(32-FW){1'b0}}, flags_ff[i*FW +: FW]};
                nxt_err   = 1'b0;
            end
            // Shown live, not as of the last report.
            if (hit_ch(paddr, ain_fault_pkg::OFS_CJCTEMP0, i)) begin
                nxt_rdata = {{(32-DATA_W){1'b0}}, cj_data[i*DATA_W +: DATA_W]};
                nxt_err   = 1'b0;
            end
            if (hit_ch(paddr, ain_fault_pkg::OFS_DATA0, i)) begin
                nxt_rdata = {{(32-DATA_W){1'b0}}, data_ff[i*DATA_W +: DATA_W]};
                nxt_err   = 1'b0;
            end
        end
    end

    // Read data is registered at the setup edge: the access phase still
    // answers with no wait state, and prdata comes straight from a
    // flip-flop, cleared again as soon as the access ends.
    logic [31:0] rdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign prdata  = rdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & nxt_err;

endmodule

// ==== test/analog_input_fault_status_asserts.sv ====
`timescale 1ns/1ps
module analog_input_fault_status_asserts #(
    parameter int NUM_CH = 4,
    parameter int DATA_W = 16
) (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic                     sample_strobe,
    input wire logic [NUM_CH-1:0]        alarm_cond,
    input wire logic                     owner_link_ok,
    input wire logic                     report_valid,
    input wire logic [NUM_CH*DATA_W-1:0] report_data,
    input wire logic [NUM_CH*8-1:0]      report_flags,
    input wire logic                     owner_link_lost_flag
);
    logic [NUM_CH-1:0] wb;
    logic [NUM_CH-1:0] bq;
    logic [NUM_CH-1:0] al;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            wb[i] = report_flags[i*8+ain_fault_pkg::FLG_WIRE_BREAK];
            bq[i] = report_flags[i*8+ain_fault_pkg::FLG_BAD_QUAL];
            al[i] = report_flags[i*8+ain_fault_pkg::FLG_ALARM];
        end
    end

    sequence s_strobe;
        sample_strobe;
    endsequence
    sequence s_report;
        report_valid;
    endsequence

    a_valid_follow: assert property (s_strobe |=> s_report)
        else $error("report_valid missing after strobe");
    a_valid_spurious: assert property (!sample_strobe |=> !report_valid)
        else $error("report_valid without strobe");
    a_report_holds: assert property (!sample_strobe |=>
        $stable(report_flags) && $stable(report_data))
        else $error("report changed without strobe");
    a_wire_faults: assert property (s_report |-> (wb & ~bq) == '0)
        else $error("wire break without fault flag");
    a_no_wire_alarm: assert property (
        sample_strobe && alarm_cond == '0 |=> al == '0)
        else $error("alarm raised without alarm condition");
    a_link_lost_set: assert property (
        !owner_link_ok [*4] |-> owner_link_lost_flag)
        else $error("link lost flag not raised");
    a_link_ok_clear: assert property (
        owner_link_ok [*4] |-> !owner_link_lost_flag)
        else $error("link lost flag stuck");
    a_bus_idle_quiet: assert property (
        !(psel && penable) |-> prdata == '0 && !pslverr && pready)
        else $error("bus outputs active outside access");
endmodule

bind analog_input_fault_status analog_input_fault_status_asserts #(
    .NUM_CH(NUM_CH),
    .DATA_W(DATA_W)
) u_asserts (.pclk, .presetn, .psel, .penable, .prdata, .pready,
    .pslverr, .sample_strobe, .alarm_cond, .owner_link_ok, .report_valid,
    .report_data, .report_flags, .owner_link_lost_flag);

// ==== test/report_sink.sv ====
`timescale 1ns/1ps
// Stands for the owning controller and its listeners: keeps the last report.
module report_sink (
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         report_valid,
    input wire logic [63:0]  report_data,
    input wire logic [31:0]  report_flags,
    output logic     [63:0]  seen_data,
    output logic     [31:0]  seen_flags
);
    // Data and flags are taken in the same cycle, so they always match.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_data <= 64'h0;
            seen_flags <= 32'h0;
        end else if (report_valid) begin
            seen_data <= report_data;
            seen_flags <= report_flags;
        end
    end
endmodule

// ==== test/analog_input_fault_status_test.sv ====
`timescale 1ns/1ps
module analog_input_fault_status_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        sample_strobe, over_temp, owner_link_ok, report_valid;
    logic        owner_link_lost_flag, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, report_flags, seen_flags;
    logic [63:0] raw_data, cj_data, report_data, seen_data;
    logic [3:0]  raw_full_scale, raw_low_current, raw_wire_open;
    logic [3:0]  raw_bad_quality, cj_wire_open, cj_bad_quality, alarm_cond;
    logic [11:0] report_units;
    int          fail_count, compares;

    analog_input_fault_status i_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_strobe,
        .raw_data, .cj_data, .raw_full_scale, .raw_low_current,
        .raw_wire_open, .raw_bad_quality, .cj_wire_open, .cj_bad_quality,
        .alarm_cond, .over_temp, .owner_link_ok, .report_valid, .report_data,
        .report_flags, .report_units, .owner_link_lost_flag);
    report_sink i_sink (.pclk, .presetn, .report_valid, .report_data,
        .report_flags, .seen_data, .seen_flags);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Three idle edges first so the field synchronisers have settled.
    task automatic strobe;
        repeat (3) @(posedge pclk);
        sample_strobe <= 1'b1;
        @(posedge pclk);
        sample_strobe <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic set_in(input logic [2:0] v);
        raw_low_current <= {3'h0, v[0]};
        raw_full_scale <= {3'h0, v[1]};
        raw_wire_open <= {3'h0, v[2]};
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, ain_fault_pkg::OFS_CHCFG0, 32'h0);
        chk(rd, ain_fault_pkg::RST_CHCFG);
        apb(1'b0, ain_fault_pkg::OFS_MINVAL0, 32'h0);
        chk(rd, ain_fault_pkg::RST_MINVAL);
        apb(1'b1, 8'hF0, 32'hFFFF_FFFF);
        apb(1'b0, 8'hF0, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        $display("t_regs done");
    endtask

    task automatic t_wire;
        logic [2:0] hit;
        for (int m = 0; m < 4; m++) begin
            hit = (m == 0) ? 3'h1 : (m == 1) ? 3'h2 : 3'h4;
            apb(1'b1, ain_fault_pkg::OFS_CHCFG0, 32'h60 | 32'(m));
            set_in(hit);
            strobe();
            chk(seen_flags, 32'h03);
            set_in(~hit);
            strobe();
            chk(seen_flags, 32'h00);
            apb(1'b1, ain_fault_pkg::OFS_CHCFG0, 32'h40 | 32'(m));
            set_in(hit);
            strobe();
            chk(seen_flags, 32'h00);
        end
        apb(1'b1, ain_fault_pkg::OFS_GLOBAL, 32'h1);
        apb(1'b1, ain_fault_pkg::OFS_CHCFG0, 32'h23);
        strobe();
        chk(seen_flags, 32'h03);
        set_in(3'h0);
        $display("t_wire done");
    endtask

    task automatic t_alarm;
        apb(1'b1, ain_fault_pkg::OFS_CHCFG0, 32'h60);
        alarm_cond <= 4'h1;
        strobe();
        chk(seen_flags, 32'h00);
        apb(1'b1, ain_fault_pkg::OFS_GLOBAL, 32'h0);
        strobe();
        chk(seen_flags, 32'h80);
        alarm_cond <= 4'h0;
        $display("t_alarm done");
    endtask

    task automatic t_units;
        for (int i = 0; i < 4; i++)
            apb(1'b1, 8'(ain_fault_pkg::OFS_CHCFG0 + 4 * i),
                32'h20 | 32'((i + 1) << 2));
        strobe();
        chk({20'h0, report_units}, 32'h8D1);
        apb(1'b1, ain_fault_pkg::OFS_CHCFG0, 32'h20);
        strobe();
        chk({20'h0, report_units}, 32'h8D0);
        apb(1'b1, ain_fault_pkg::OFS_CHCFG0, 32'h3C);
        apb(1'b0, ain_fault_pkg::OFS_CHCFG0, 32'h0);
        chk(rd, 32'h30);
        $display("t_units done");
    endtask

    task automatic t_cjc;
        apb(1'b1, ain_fault_pkg::OFS_CHCFG0, 32'h23);
        raw_data <= 64'h64;
        cj_data <= 64'h5;
        strobe();
        chk(seen_data[31:0], 32'h69);
        apb(1'b1, ain_fault_pkg::OFS_GLOBAL, 32'h2);
        strobe();
        chk(seen_data[31:0], 32'h64);
        apb(1'b0, ain_fault_pkg::OFS_DATA0, 32'h0);
        chk(rd, 32'h64);
        apb(1'b1, ain_fault_pkg::OFS_GLOBAL, 32'h0);
        apb(1'b1, ain_fault_pkg::OFS_CHCFG0, 32'h20);
        $display("t_cjc done");
    endtask

    task automatic t_levels;
        apb(1'b1, ain_fault_pkg::OFS_MINVAL0, 32'h10);
        raw_data <= 64'h5;
        cj_data <= 64'h3;
        over_temp <= 1'b1;
        strobe();
        chk(seen_flags, 32'h0808_084C);
        apb(1'b0, ain_fault_pkg::OFS_FLAGS0, 32'h0);
        chk(rd, 32'h4C);
        raw_data <= 64'h20;
        cj_data <= 64'h20;
        over_temp <= 1'b0;
        raw_bad_quality <= 4'h2;
        cj_bad_quality <= 4'h4;
        strobe();
        chk(seen_flags, 32'h0020_0200);
        raw_bad_quality <= 4'h0;
        cj_bad_quality <= 4'h0;
        cj_wire_open <= 4'h8;
        strobe();
        chk({31'h0, seen_flags[28]}, 32'h1);
        cj_wire_open <= 4'h0;
        strobe();
        chk(seen_flags, 32'h0);
        $display("t_levels done");
    endtask

    task automatic t_link;
        owner_link_ok <= 1'b0;
        repeat (5) @(posedge pclk);
        chk({31'h0, owner_link_lost_flag}, 32'h1);
        apb(1'b0, ain_fault_pkg::OFS_MODFLAGS, 32'h0);
        chk(rd, 32'h1);
        owner_link_ok <= 1'b1;
        repeat (5) @(posedge pclk);
        chk({31'h0, owner_link_lost_flag}, 32'h0);
        $display("t_link done");
    endtask

    task automatic results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, sample_strobe, over_temp} = '0;
        {paddr, pwdata, raw_data, cj_data} = '0;
        {raw_full_scale, raw_low_current, raw_wire_open} = '0;
        {raw_bad_quality, cj_wire_open, cj_bad_quality, alarm_cond} = '0;
        owner_link_ok = 1'b1;
        fail_count = 0;
        compares = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_wire();
        t_alarm();
        t_units();
        t_cjc();
        t_levels();
        t_link();
        results();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end
endmodule
